// *** core/ahb_regs.sv ***
`timescale 1ns/10ps
// AHB-Lite slave front end: latches address phase, zero wait states
module ahb_regs
  import cnt_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, low
  input wire ahb_req_t req, // Address phase signals
  input wire logic hready, // Bus ready
  output logic wr_en, // Data-phase write strobe
  output logic rd_en, // Data-phase read strobe
  output logic [7:0] addr // Latched offset
);
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
  } ph_t;
  ph_t s_r, s_nxt;

  // Only NONSEQ/SEQ with hsel start a transfer
  always_comb begin
    s_nxt.wr = hready && req.hsel && req.htrans[1] && req.hwrite;
    s_nxt.rd = hready && req.hsel && req.htrans[1] && !req.hwrite;
    s_nxt.addr = req.haddr[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wr_en = s_r.wr;
  assign rd_en = s_r.rd;
  assign addr = s_r.addr;
endmodule : ahb_regs

// *** core/contact_counter.sv ***
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
module contact_counter
  import cnt_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int MS_TICKS = MS_CYCLES
) (
  input wire logic hclk, // Clock, 20 MHz
  input wire logic hresetn, // Async reset, low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB direction
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic hready, // AHB ready in
  input wire logic [31:0] hwdata, // AHB write data
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  input wire logic [1:0] contact, // Field contacts, point1 at bit 0
  input wire logic freeze_cmd, // Protocol freeze pulse
  output logic irq // Level interrupt
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [9:0] debounce;
    logic [19:0] chatter;
    logic [WIDTH-1:0] init_val;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] frozen;
    logic restart;
    logic roll;
    logic [1:0] prev;
    bp_state_t bp;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [31:0] rdata;
  } st_t;
  st_t s_r, s_nxt;

  logic [1:0] lvl;
  logic [1:0] supp;
  logic wr_en, rd_en;
  logic [7:0] addr;
  logic [7:0] qual;
  logic inc, frz, pol, counting_on;
  cnt_type_t ctype;
  logic [WIDTH-1:0] count_inc;
  logic [31:0] rd_mux;
  ahb_req_t req;

  assign req = '{htrans: htrans, haddr: haddr, hwrite: hwrite, hsel: hsel};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_en ? rd_mux : s_r.rdata; // Valid in the data phase, then held
  assign irq = |(s_r.irq_stat & s_r.irq_mask);

  ahb_regs i_ahb_regs (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(req),
    .hready(hready),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .addr(addr)
  );

  // One filter per contact
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_flt
      contact_filter #(.MS_TICKS(MS_TICKS)) i_contact_filter (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(contact[g]),
        .debounce_ms(s_r.debounce),
        .window_long(s_r.ctrl[CTRL_WINDOW_LONG_BIT]),
        .chat_on(s_r.chatter[9:0]),
        .chat_off(s_r.chatter[19:10]),
        .level(lvl[g]),
        .suppressed(supp[g])
      );
    end
  endgenerate

  assign ctype = cnt_type_t'(s_r.ctrl[CTRL_TYPE_LSB +: 2]);
  assign pol = s_r.ctrl[CTRL_POL_BIT];
  // A contact claimed as status input never counts
  assign counting_on = !s_r.ctrl[CTRL_STATUS_USE_BIT];
  assign frz = freeze_cmd && s_r.ctrl[CTRL_FROZEN_BIT];
  assign count_inc = s_r.count + {{(WIDTH-1){1'b0}}, 1'b1}; // natural wrap

  // Increment decision per counter type
  always_comb begin
    inc = 1'b0;
    case (ctype)
      TYPE_BINARY: begin
        inc = (lvl[0] != s_r.prev[0]) && (lvl[0] == pol);
      end
      TYPE_THREE_WIRE: begin
        // Both must flip together into opposite states
        inc = (lvl[0] != s_r.prev[0]) && (lvl[1] != s_r.prev[1]) &&
              (lvl[0] != lvl[1]) && (lvl[0] == pol);
      end
      TYPE_BREAKER_PAIR: begin
        // Chain 10 -> 11 -> 01 (bit 1 = p2) style: p1 moves first, then p2 into the state opposite p1
        inc = (s_r.bp == BP_WAIT_P2) && (lvl[1] != s_r.prev[1]) &&
              (lvl[1] != lvl[0]) && (lvl[0] == s_r.prev[0]);
      end
      default: begin
        inc = 1'b0;
      end
    endcase
    inc = inc && counting_on;
  end

  // Quality word
  always_comb begin
    qual = 8'h00;
    qual[Q_ONLINE] = s_r.ctrl[CTRL_ONLINE_BIT];
    qual[Q_COMM_LOST] = !s_r.ctrl[CTRL_ONLINE_BIT];
    qual[Q_RESTART] = s_r.restart;
    qual[Q_REMOTE_FORCED] = s_r.ctrl[CTRL_REMOTE_FORCE_BIT];
    qual[Q_LOCAL_FORCED] = s_r.ctrl[CTRL_LOCAL_FORCE_BIT];
    qual[Q_ROLL_OVER] = s_r.roll;
    qual[Q_REF_CHECK] = !s_r.ctrl[CTRL_REF_SET_BIT];
    qual[Q_CONFIG_ERR] = s_r.ctrl[CTRL_STATUS_USE_BIT];
  end

  // Read multiplexer, unmapped reads zero
  always_comb begin
    case (addr)
      OFS_CTRL: rd_mux = s_r.ctrl;
      OFS_DEBOUNCE: rd_mux = {22'h000000, s_r.debounce};
      OFS_CHATTER: rd_mux = {12'h000, s_r.chatter};
      OFS_INIT: rd_mux = 32'(s_r.init_val);
      OFS_COUNT: rd_mux = 32'(s_r.count);
      OFS_FROZEN: rd_mux = 32'(s_r.frozen);
      OFS_QUAL: rd_mux = {22'h000000, supp, qual};
      OFS_IRQ_STAT: rd_mux = {28'h0000000, s_r.irq_stat};
      OFS_IRQ_MASK: rd_mux = {28'h0000000, s_r.irq_mask};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Counting, freezing, registers and interrupts
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = lvl;
    if (ctype == TYPE_BREAKER_PAIR && counting_on) begin
      if (s_r.bp == BP_WAIT_P1 && lvl[0] != s_r.prev[0] && lvl[1] == s_r.prev[1]) begin
        s_nxt.bp = BP_WAIT_P2; // point one moved first
      end else if (s_r.bp == BP_WAIT_P2 && lvl[1] != s_r.prev[1]) begin
        s_nxt.bp = BP_WAIT_P1;
      end
    end
    if (rd_en) begin
      s_nxt.rdata = rd_mux;
      if (addr == OFS_IRQ_STAT) begin
        s_nxt.irq_stat = 4'h0;
      end
    end
    if (wr_en) begin
      case (addr)
        OFS_CTRL: s_nxt.ctrl = hwdata;
        OFS_DEBOUNCE: s_nxt.debounce = (hwdata[9:0] > 10'(DEBOUNCE_MAX_MS)) ? 10'(DEBOUNCE_MAX_MS) : hwdata[9:0];
        OFS_CHATTER: s_nxt.chatter = hwdata[19:0];
        OFS_INIT: s_nxt.init_val = hwdata[WIDTH-1:0];
        OFS_IRQ_MASK: s_nxt.irq_mask = hwdata[3:0];
        OFS_CMD: begin
          if (hwdata[CMD_INIT_BIT]) begin
            s_nxt.count = s_r.init_val;
            s_nxt.restart = 1'b0;
          end
          if (hwdata[CMD_CLR_ROLL_BIT]) begin
            s_nxt.roll = 1'b0;
          end
          if (hwdata[CMD_FREEZE_BIT] && s_r.ctrl[CTRL_FROZEN_BIT]) begin
            s_nxt.frozen = s_r.count;
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware events win over software clears
    if (inc) begin
      s_nxt.count = count_inc;
      s_nxt.irq_stat[IRQ_COUNT] = 1'b1;
      if (count_inc == '0) begin
        s_nxt.roll = 1'b1;
        s_nxt.irq_stat[IRQ_ROLL] = 1'b1;
      end
    end
    if (frz) begin
      s_nxt.frozen = s_r.count;
      s_nxt.irq_stat[IRQ_FREEZE] = 1'b1;
    end
    if (|supp) begin
      s_nxt.irq_stat[IRQ_CHATTER] = 1'b1;
    end
  end

  // Restart flag stands from reset; count clears on boot regardless of reset option
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.restart <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : contact_counter

// *** core/contact_filter.sv ***
`timescale 1ns/10ps
// Debounce plus chatter suppression for one contact
module contact_filter
  import cnt_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Async reset, low
  input wire logic raw, // Contact level
  input wire logic [9:0] debounce_ms, // 0 disables
  input wire logic window_long, // 1000 ms window
  input wire logic [9:0] chat_on, // Trigger count, 0 off
  input wire logic [9:0] chat_off, // Hysteresis count
  output logic level, // Accepted level
  output logic suppressed // Chatter active
);
  typedef struct packed {
    logic [15:0] tick;
    logic [9:0] stable_ms;
    logic [9:0] win_ms;
    logic [9:0] changes;
    logic deb;
    logic level;
    logic supp;
  } flt_t;
  flt_t s_r, s_nxt;
  logic ms_pulse;

  assign level = s_r.level;
  assign suppressed = s_r.supp;

  // Millisecond tick, debounce age, chatter window
  always_comb begin
    s_nxt = s_r;
    ms_pulse = (s_r.tick == 16'(MS_TICKS - 1));
    s_nxt.tick = ms_pulse ? 16'h0000 : s_r.tick + 16'h0001;
    if (raw == s_r.deb) begin
      s_nxt.stable_ms = 10'h000;
    end else if (debounce_ms == 10'h000 || (s_r.stable_ms >= debounce_ms && ms_pulse)) begin
      s_nxt.stable_ms = 10'h000;
      s_nxt.deb = raw;
      // Saturate so a fast chatter cannot wrap the change count back under the trigger
      if (s_r.changes != 10'h3ff) begin
        s_nxt.changes = s_r.changes + 10'h001;
      end
    end else if (ms_pulse && s_r.stable_ms != 10'h3ff) begin
      s_nxt.stable_ms = s_r.stable_ms + 10'h001;
    end
    if (ms_pulse) begin
      s_nxt.win_ms = s_r.win_ms + 10'h001;
      if (s_r.win_ms == 10'(window_long ? WIN_LONG_MS - 1 : WIN_SHORT_MS - 1)) begin
        // Window boundary decides entry and release
        s_nxt.win_ms = 10'h000;
        s_nxt.changes = 10'h000;
        if (chat_on != 10'h000 && s_r.changes >= chat_on) begin
          s_nxt.supp = 1'b1;
        end else if (s_r.changes < chat_off) begin
          s_nxt.supp = 1'b0;
        end
      end
    end
    // Suppression holds the reported level; changes are still counted underneath
    if (!s_nxt.supp) begin
      s_nxt.level = s_nxt.deb;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : contact_filter

// *** include/cnt_pkg.sv ***
package cnt_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DEBOUNCE = 8'h04;
  localparam logic [7:0] OFS_CHATTER = 8'h08;
  localparam logic [7:0] OFS_INIT = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;
  localparam logic [7:0] OFS_FROZEN = 8'h18;
  localparam logic [7:0] OFS_QUAL = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  // CTRL fields
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_FROZEN_BIT = 2;
  localparam int CTRL_POL_BIT = 3;
  localparam int CTRL_STATUS_USE_BIT = 4;
  localparam int CTRL_RESET_ON_BOOT_BIT = 5;
  localparam int CTRL_ONLINE_BIT = 6;
  localparam int CTRL_REF_SET_BIT = 7;
  localparam int CTRL_REMOTE_FORCE_BIT = 8;
  localparam int CTRL_LOCAL_FORCE_BIT = 9;
  localparam int CTRL_WINDOW_LONG_BIT = 10;
  // CMD bits (write one)
  localparam int CMD_FREEZE_BIT = 0;
  localparam int CMD_INIT_BIT = 1;
  localparam int CMD_CLR_ROLL_BIT = 2;
  // Quality / irq bits
  localparam int Q_ONLINE = 0;
  localparam int Q_RESTART = 1;
  localparam int Q_COMM_LOST = 2;
  localparam int Q_REMOTE_FORCED = 3;
  localparam int Q_LOCAL_FORCED = 4;
  localparam int Q_ROLL_OVER = 5;
  localparam int Q_REF_CHECK = 6;
  localparam int Q_CONFIG_ERR = 7;
  localparam int IRQ_COUNT = 0;
  localparam int IRQ_ROLL = 1;
  localparam int IRQ_FREEZE = 2;
  localparam int IRQ_CHATTER = 3;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam int DEBOUNCE_MAX_MS = 1000;
  localparam int WIN_SHORT_MS = 100;
  localparam int WIN_LONG_MS = 1000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    TYPE_BINARY = 2'h0,
    TYPE_THREE_WIRE = 2'h1,
    TYPE_BREAKER_PAIR = 2'h2
  } cnt_type_t;

  // Alternation tracker for breaker pair mode, gray ordered
  typedef enum logic [1:0] {
    BP_WAIT_P1 = 2'b00,
    BP_WAIT_P2 = 2'b01
  } bp_state_t;

  typedef struct packed {
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic hsel;
  } ahb_req_t;
endpackage : cnt_pkg

// *** sim/contact_counter_properties.sv ***
`timescale 1ns/10ps
module contact_counter_checker
  import cnt_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, low
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Direction
  input wire logic hready, // Ready in
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic [1:0] contact, // Contacts
  input wire logic freeze_cmd, // Freeze
  input wire logic irq // Interrupt
);
  logic take_w;
  logic [2:0] hist_r;
  assign take_w = hsel && htrans[1] && hready;
  // Sticky history: mask written, freeze seen, count may have moved
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hist_r <= 3'h0;
    end else begin
      hist_r <= hist_r | {take_w && hwrite && haddr[7:0] == OFS_IRQ_MASK, freeze_cmd || (take_w && hwrite),
                          (take_w && hwrite) || contact != $past(contact)};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
  chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
  chk_idle_hold: assert property (!take_w |=> $stable(hrdata)) else $error("hrdata moved when idle");
  chk_write_hold: assert property (take_w && hwrite |=> $stable(hrdata)) else $error("hrdata moved on write");
  chk_unmapped_zero: assert property (take_w && !hwrite && haddr[7:0] > OFS_IRQ_MASK |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_clear: assert property ($fell(irq) |-> $past(take_w) || $past(take_w, 2))
    else $error("irq fell without access");
  chk_reset_quiet: assert property ($rose(hresetn) |-> !irq && hrdata == 32'h0) else $error("not quiet");
  chk_irq_masked: assert property (irq |-> hist_r[2]) else $error("irq while never unmasked");
  chk_frozen_zero: assert property (take_w && !hwrite && haddr[7:0] == OFS_FROZEN && !hist_r[1] && !freeze_cmd |=>
    hrdata == 32'h0) else $error("frozen value without freeze");
  chk_count_quiet: assert property (take_w && !hwrite && haddr[7:0] == OFS_COUNT && !hist_r[0] |=>
    hrdata == 32'h0) else $error("count moved on its own");
endmodule : contact_counter_checker
bind contact_counter contact_counter_checker i_chk (.*);

// *** sim/field_contacts.sv ***
`timescale 1ns/10ps
// Dry field contacts; they move only when the bench commands a new position
module field_contacts (
  input wire logic hclk, // Clock
  input wire logic [1:0] pos, // Commanded position
  output logic [1:0] contact = 2'h0 // Contact levels
);
  // No bounce modelled, so debounce is zero except in the filter test
  always @(posedge hclk) begin
    contact <= pos;
  end
endmodule : field_contacts

// *** sim/test_contact_counter.sv ***
`timescale 1ns/10ps
module test_contact_counter
  import cnt_pkg::*;
;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, freeze = 1'b0;
  logic [1:0] htrans = 2'h0, pos = 2'h0, contact;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, irq;
  int errors = 0, checks = 0;
  always #25 hclk = ~hclk;
  // Short ms tick keeps filter timing cheap
  contact_counter #(.MS_TICKS(4)) i_contact_counter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .contact(contact), .freeze_cmd(freeze), .irq(irq));
  field_contacts i_field_contacts (.hclk(hclk), .pos(pos), .contact(contact));
  task automatic summarize;
    if (errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Bounded wait for hready; a stuck slave ends the run
  task automatic edge_rdy;
    for (int n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    errors++;
    summarize();
  endtask : edge_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    edge_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    edge_rdy();
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  // Filter plus count latency is two cycles; six leaves margin
  task automatic mv(input logic [1:0] v);
    pos <= v;
    repeat (6) @(posedge hclk);
  endtask : mv
  task automatic frz;
    freeze <= 1'b1;
    @(posedge hclk);
    freeze <= 1'b0;
    @(posedge hclk);
  endtask : frz
  task automatic setup(input logic [31:0] c, input logic [31:0] i);
    bus(1'b1, OFS_CTRL, c);
    bus(1'b1, OFS_INIT, i);
    bus(1'b1, OFS_CMD, 32'h2);
  endtask : setup
  task automatic t_reset;
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_QUAL, 32'h46);
    rdc(OFS_COUNT, 32'h0);
    rdc(8'h28, 32'h0);
  endtask : t_reset
  task automatic t_flags;
    setup(32'h3c8, 32'h5);
    rdc(OFS_COUNT, 32'h5);
    rdc(OFS_QUAL, 32'h19);
    bus(1'b1, OFS_CTRL, 32'h048);
    rdc(OFS_QUAL, 32'h41);
    bus(1'b1, OFS_CTRL, 32'h0c8);
    rdc(OFS_QUAL, 32'h01);
  endtask : t_flags
  task automatic t_binary;
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    mv(2'b01);
    mv(2'b00);
    mv(2'b01);
    rdc(OFS_COUNT, 32'h7);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_IRQ_STAT, 32'h1);
    @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0c0);
    mv(2'b00);
    mv(2'b01);
    rdc(OFS_COUNT, 32'h8);
    bus(1'b1, OFS_CTRL, 32'h0d0);
    mv(2'b00);
    rdc(OFS_COUNT, 32'h8);
    rdc(OFS_QUAL, 32'h81);
  endtask : t_binary
  task automatic t_wrap;
    setup(32'h0c8, 32'hffff_ffff);
    mv(2'b01);
    rdc(OFS_COUNT, 32'h0);
    rdc(OFS_QUAL, 32'h21);
    mv(2'b00);
    mv(2'b01);
    rdc(OFS_COUNT, 32'h1);
    bus(1'b1, OFS_CMD, 32'h4);
    rdc(OFS_QUAL, 32'h01);
  endtask : t_wrap
  task automatic t_freeze;
    frz();
    rdc(OFS_FROZEN, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0cc);
    frz();
    rdc(OFS_FROZEN, 32'h1);
    mv(2'b00);
    mv(2'b01);
    rdc(OFS_COUNT, 32'h2);
    rdc(OFS_FROZEN, 32'h1);
    bus(1'b1, OFS_CMD, 32'h1);
    rdc(OFS_FROZEN, 32'h2);
  endtask : t_freeze
  // Single-point moves never count; one of the two swaps does
  task automatic t_pair;
    setup(32'h0c9, 32'h0);
    mv(2'b11);
    mv(2'b10);
    mv(2'b01);
    mv(2'b10);
    rdc(OFS_COUNT, 32'h1);
  endtask : t_pair
  task automatic t_breaker;
    setup(32'h0ca, 32'h0);
    mv(2'b00);
    mv(2'b10);
    mv(2'b11);
    mv(2'b01);
    rdc(OFS_COUNT, 32'h1);
  endtask : t_breaker
  // Debounce of 3 ms: a 1 ms blip is dropped, a held level counts once
  task automatic t_filter;
    setup(32'h0c8, 32'h0);
    bus(1'b1, OFS_DEBOUNCE, 32'h3ff);
    rdc(OFS_DEBOUNCE, DEBOUNCE_MAX_MS);
    bus(1'b1, OFS_DEBOUNCE, 32'h3);
    pos <= 2'b00;
    repeat (30) @(posedge hclk);
    pos <= 2'b01;
    repeat (4) @(posedge hclk);
    pos <= 2'b00;
    repeat (30) @(posedge hclk);
    rdc(OFS_COUNT, 32'h0);
    pos <= 2'b01;
    repeat (30) @(posedge hclk);
    rdc(OFS_COUNT, 32'h1);
    bus(1'b1, OFS_DEBOUNCE, 32'h0);
  endtask : t_filter
  // Four quick changes trip a trigger of two; a quiet window releases it
  task automatic t_chatter;
    bus(1'b1, OFS_CHATTER, 32'h0000_0402);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    mv(2'b00);
    mv(2'b01);
    mv(2'b00);
    mv(2'b01);
    repeat (1300) @(posedge hclk);
    rdc(OFS_IRQ_STAT, 32'h9);
    rdc(OFS_QUAL, 32'h01);
    bus(1'b1, OFS_CHATTER, 32'h0);
  endtask : t_chatter
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_flags();
    t_binary();
    t_wrap();
    t_freeze();
    t_pair();
    t_breaker();
    t_filter();
    t_chatter();
    summarize();
  end
endmodule : test_contact_counter
